/* verilog/dec_status_defines.svh */
// Purpose: Offsets, field positions and reset values of the decoder status registers
// Assumes: Included by bare name from the package and decoder_status_regs
// Notes: Definitions only
`ifndef DEC_STATUS_DEFINES_SVH
`define DEC_STATUS_DEFINES_SVH

// ==========================================================================
// Local addresses
`define ADDR_RESUME 8'h00
`define ADDR_EVENT_MASK 8'h1d
`define ADDR_EVENT_FLAGS 8'h1e
`define ADDR_DECODED_HDR 8'h21
`define ADDR_APPLIED_HDR 8'h22
`define ADDR_ERROR_REPORT 8'h24

// ==========================================================================
// Event bit positions
`define EVT_SYNC_LOST 0
`define EVT_SYNC_ACQ 1
`define EVT_CRC_FAIL 2
`define EVT_STOP 3
`define EVT_FRAME_READY 4
`define EVT_COUNT 5

// ==========================================================================
// Reset values and fixed fields
`define EVENT_MASK_RESET 5'h00
`define HDR_RESET 24'h000000
`define ERR_RESET 8'h00
`define HDR_BYTES 2'h3
// Header byte 1 forced ones: sync tail bits 7..4 and layer bit 2
`define HDR1_FORCE_ONES 8'hf4

// ==========================================================================
// Error report fields
`define ERR_ALLOC_BIT 7
`define ERR_DECODED_BIT 6

`endif

/* verilog/dec_status_pkg.sv */
// Purpose: Types shared by the decoder status register block
// Assumes: Constants live in dec_status_defines.svh
// Notes: Types only
`include "dec_status_defines.svh"
package dec_status_pkg;
  typedef enum logic [1:0] {
    XFER_IDLE = 2'b01,
    XFER_OPEN = 2'b10
  } xfer_state_e;
  typedef logic [`EVT_COUNT-1:0] event_vec_t;
endpackage

/* verilog/pin_rise_detect.sv */
// Purpose: Three-stage synchroniser with rising-edge pulse for an outside pin
// Assumes: Pin is asynchronous to CLK
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
module pin_rise_detect (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PIN,
  output logic RISE
);
  logic [2:0] stage;
  logic level;
  logic [2:0] next_stage;
  logic next_level;
  logic next_rise;

  always_comb begin
    next_stage = {stage[1:0], PIN};
    next_level = level;
    // A change counts once stages two and three agree
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
    next_rise = next_level & ~level;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stage <= 3'h0;
      level <= 1'b0;
      RISE <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
      RISE <= next_rise;
    end
  end
endmodule // pin_rise_detect

/* verilog/sticky_flag.sv */
// Purpose: One sticky event flag, set by hardware and cleared by the host
// Assumes: SET and CLR are single-cycle pulses on CLK
// Notes: A set in the clearing cycle wins so no event is lost
`timescale 1ns/100ps
module sticky_flag (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic SET,
  input wire logic CLR,
  output logic FLAG
);
  logic next_flag;

  always_comb begin
    next_flag = FLAG;
    if (CLR) begin
      next_flag = 1'b0;
    end
    if (SET) begin
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FLAG <= 1'b0;
    end else begin
      FLAG <= next_flag;
    end
  end
endmodule // sticky_flag

/* verilog/decoder_status_regs.sv */
// Purpose: Status and interrupt local registers of the audio decoder
// Assumes: Control link front end delivers byte selects, reads and writes on CLK
// Notes: Event register clears on read; write-only and unmapped reads give zero
`timescale 1ns/100ps
`include "dec_status_defines.svh"
module decoder_status_regs (
  input wire logic CLK,
  input wire logic SYS_RST,
  // Local register access from the control link front end
  input wire logic LOC_SEL,
  input wire logic [7:0] LOC_ADDR,
  input wire logic LOC_WR,
  input wire logic [7:0] LOC_WDATA,
  input wire logic LOC_RD,
  output logic [7:0] LOC_RDATA,
  output logic LOC_RVALID,
  // Decoder core status
  input wire logic FRAME_READY,
  input wire logic STOP_PIN,
  input wire logic CRC_FAIL,
  input wire logic IN_SYNC,
  input wire logic DEC_HDR_STB,
  input wire logic [23:0] DEC_HDR,
  input wire logic ALLOC_VALID,
  input wire logic FRAME_DECODED,
  input wire logic SF_CRC_ENA,
  input wire logic [31:0] SB_CONCEALED,
  // Outputs to pins and datapath
  output logic INT_REQ,
  output logic [1:0] DEEMPH_MODE
);
  import dec_status_pkg::*;

  // ==========================================================================
  // Event sources
  logic ready_seen;
  logic sync_seen;
  logic stop_rise;
  event_vec_t evt_set;
  event_vec_t evt_clr;
  event_vec_t evt_flags;
  logic next_ready_seen;
  logic next_sync_seen;

  pin_rise_detect u_stop (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .PIN(STOP_PIN),
    .RISE(stop_rise)
  );

  always_comb begin
    next_ready_seen = FRAME_READY;
    next_sync_seen = IN_SYNC;
    evt_set[`EVT_FRAME_READY] = FRAME_READY & ~ready_seen;
    evt_set[`EVT_STOP] = stop_rise;
    evt_set[`EVT_CRC_FAIL] = CRC_FAIL;
    evt_set[`EVT_SYNC_ACQ] = IN_SYNC & ~sync_seen;
    evt_set[`EVT_SYNC_LOST] = ~IN_SYNC & sync_seen;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ready_seen <= 1'b0;
      sync_seen <= 1'b0;
    end else begin
      ready_seen <= next_ready_seen;
      sync_seen <= next_sync_seen;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `EVT_COUNT; gi = gi + 1) begin : g_flag
      sticky_flag u_flag (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .SET(evt_set[gi]),
        .CLR(evt_clr[gi]),
        .FLAG(evt_flags[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // Frame header and error report capture
  logic [23:0] decoded_frame_header;
  logic [23:0] applied_frame_header;
  logic [7:0] frame_error_report;
  logic [23:0] next_decoded;
  logic [23:0] next_applied;
  logic [7:0] next_error;
  logic [3:0] scalefactor_block_ok;
  logic frame_event;

  assign frame_event = evt_set[`EVT_FRAME_READY];

  always_comb begin
    next_decoded = decoded_frame_header;
    next_applied = applied_frame_header;
    next_error = frame_error_report;
    if (DEC_HDR_STB) begin
      next_decoded = DEC_HDR;
    end
    scalefactor_block_ok[0] = ~|SB_CONCEALED[3:0];
    scalefactor_block_ok[1] = ~|SB_CONCEALED[7:4];
    scalefactor_block_ok[2] = ~|SB_CONCEALED[15:8];
    scalefactor_block_ok[3] = ~|SB_CONCEALED[31:16];
    if (frame_event && IN_SYNC) begin
      if (FRAME_DECODED) begin
        // Forced fields; skipped frames keep last good header
        next_applied = {decoded_frame_header[23:16] | `HDR1_FORCE_ONES,
                        decoded_frame_header[15:10], 2'h0,
                        decoded_frame_header[7:0]};
      end
      next_error = 8'h00;
      next_error[`ERR_ALLOC_BIT] = ALLOC_VALID;
      next_error[`ERR_DECODED_BIT] = FRAME_DECODED;
      // Block results only with CRCs on
      if (SF_CRC_ENA) begin
        next_error[3:0] = scalefactor_block_ok;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      decoded_frame_header <= `HDR_RESET;
      applied_frame_header <= `HDR_RESET;
      frame_error_report <= `ERR_RESET;
    end else begin
      decoded_frame_header <= next_decoded;
      applied_frame_header <= next_applied;
      frame_error_report <= next_error;
    end
  end

  assign DEEMPH_MODE = applied_frame_header[1:0];

  // ==========================================================================
  // Local register access
  xfer_state_e state;
  xfer_state_e next_state;
  logic [7:0] cur_addr;
  logic [7:0] rest_addr;
  logic [1:0] rest_idx;
  logic [4:0] event_mask;
  logic [7:0] next_cur_addr;
  logic [7:0] next_rest_addr;
  logic [1:0] next_rest_idx;
  logic [4:0] next_mask;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic restricted_sel;
  logic restricted_cur;
  logic [23:0] hdr_pick;

  always_comb begin
    restricted_sel = (LOC_ADDR == `ADDR_DECODED_HDR) || (LOC_ADDR == `ADDR_APPLIED_HDR) ||
                     (LOC_ADDR == `ADDR_ERROR_REPORT);
    restricted_cur = (cur_addr == `ADDR_DECODED_HDR) || (cur_addr == `ADDR_APPLIED_HDR) ||
                     (cur_addr == `ADDR_ERROR_REPORT);
    next_state = state;
    next_cur_addr = cur_addr;
    next_rest_addr = rest_addr;
    next_rest_idx = rest_idx;
    next_mask = event_mask;
    next_rdata = LOC_RDATA;
    next_rvalid = 1'b0;
    evt_clr = '0;
    // Pick by the saved item so a resumed transfer reads the header it left off in
    hdr_pick = (rest_addr == `ADDR_APPLIED_HDR) ? applied_frame_header : decoded_frame_header;
    case (state)
      XFER_IDLE: begin
        if (LOC_SEL) begin
          next_state = XFER_OPEN;
        end
      end
      XFER_OPEN: begin
        if (LOC_RD) begin
          next_rvalid = 1'b1;
          next_rdata = 8'h00;
          if (cur_addr == `ADDR_EVENT_FLAGS) begin
            next_rdata = {3'h0, evt_flags};
            // Clear only reported bits; a set in this cycle stays for the next read
            evt_clr = evt_flags;
          end else if (restricted_cur) begin
            // Error report single byte, undefined bits zero
            if (cur_addr == `ADDR_ERROR_REPORT) begin
              next_rdata = (rest_idx == 2'h0) ? frame_error_report : 8'h00;
            end else begin
              case (rest_idx)
                2'h0: next_rdata = hdr_pick[23:16];
                2'h1: next_rdata = hdr_pick[15:8];
                2'h2: next_rdata = hdr_pick[7:0];
                default: next_rdata = 8'h00;
              endcase
            end
            if (rest_idx != `HDR_BYTES) begin
              next_rest_idx = rest_idx + 2'h1;
            end
          end
        end
        if (LOC_WR && cur_addr == `ADDR_EVENT_MASK) begin
          next_mask = LOC_WDATA[4:0];
        end
      end
      default: begin
        next_state = XFER_IDLE;
      end
    endcase
    if (LOC_SEL) begin
      if (LOC_ADDR == `ADDR_RESUME) begin
        next_cur_addr = rest_addr;
      end else begin
        next_cur_addr = LOC_ADDR;
        if (restricted_sel) begin
          next_rest_addr = LOC_ADDR;
          next_rest_idx = 2'h0;
        end
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= XFER_IDLE;
      cur_addr <= 8'h00;
      rest_addr <= 8'h00;
      rest_idx <= 2'h0;
      event_mask <= `EVENT_MASK_RESET;
      LOC_RDATA <= 8'h00;
      LOC_RVALID <= 1'b0;
    end else begin
      state <= next_state;
      cur_addr <= next_cur_addr;
      rest_addr <= next_rest_addr;
      rest_idx <= next_rest_idx;
      event_mask <= next_mask;
      LOC_RDATA <= next_rdata;
      LOC_RVALID <= next_rvalid;
    end
  end

  // ==========================================================================
  // Interrupt output
  logic next_int;

  always_comb begin
    next_int = |(evt_flags & event_mask);
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      INT_REQ <= 1'b0;
    end else begin
      INT_REQ <= next_int;
    end
  end
endmodule // decoder_status_regs

/* verif/dec_status_regs_monitor.sv */
// Purpose: Port checker for decoder_status_regs
// Assumes: Host selects before any read or write
// Notes: Mask and selected address are shadowed here
`timescale 1ns/100ps
module dec_status_monitor (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic LOC_SEL,
  input wire logic [7:0] LOC_ADDR,
  input wire logic LOC_WR,
  input wire logic [7:0] LOC_WDATA,
  input wire logic LOC_RD,
  input wire logic [7:0] LOC_RDATA,
  input wire logic LOC_RVALID,
  input wire logic FRAME_READY,
  input wire logic CRC_FAIL,
  input wire logic IN_SYNC,
  input wire logic INT_REQ,
  input wire logic [1:0] DEEMPH_MODE
);
  logic opened, next_opened;
  logic [7:0] addr, next_addr;
  logic [4:0] mask, next_mask;
  // ==========================================================
  // Shadow state
  always_comb begin
    next_opened = opened | LOC_SEL;
    next_addr = LOC_SEL ? LOC_ADDR : addr;
    next_mask = (LOC_WR && opened && addr == 8'h1d) ? LOC_WDATA[4:0] : mask;
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      opened <= 1'h0;
      addr <= 8'h00;
      mask <= 5'h00;
    end else begin
      opened <= next_opened;
      addr <= next_addr;
      mask <= next_mask;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence rd_taken; LOC_RD && opened; endsequence
  sequence crc_open; CRC_FAIL && mask[2] ##1 mask[2]; endsequence
  AST_RD_ANSWER: assert property (rd_taken |=> LOC_RVALID)
    else $error("read not answered");
  AST_RD_HOLD: assert property (!LOC_RVALID |-> $stable(LOC_RDATA))
    else $error("read data moved");
  AST_MASK_WO: assert property (rd_taken ##0 addr == 8'h1d |=> LOC_RDATA == 8'h00)
    else $error("mask readable");
  AST_EVT_TOP: assert property (rd_taken ##0 addr == 8'h1e |=> LOC_RDATA[7:5] == 3'h0)
    else $error("event top bits set");
  AST_MASK_BLOCK: assert property ((mask == 5'h00) [*2] |=> !INT_REQ)
    else $error("masked interrupt");
  AST_CRC_INT: assert property (crc_open |=> INT_REQ)
    else $error("crc interrupt late");
  AST_ACQ_INT: assert property ($rose(IN_SYNC) && mask[1] |-> ##[1:3] INT_REQ)
    else $error("sync interrupt late");
  AST_READY_INT: assert property ($rose(FRAME_READY) && mask[4] |-> ##[1:3] INT_REQ)
    else $error("ready interrupt late");
  AST_DEEMPH: assert property (!FRAME_READY [*4] |=> $stable(DEEMPH_MODE))
    else $error("de-emphasis moved");
endmodule // dec_status_monitor

bind decoder_status_regs dec_status_monitor mon_u (.CLK(CLK), .SYS_RST(SYS_RST),
  .LOC_SEL(LOC_SEL), .LOC_ADDR(LOC_ADDR), .LOC_WR(LOC_WR), .LOC_WDATA(LOC_WDATA),
  .LOC_RD(LOC_RD), .LOC_RDATA(LOC_RDATA), .LOC_RVALID(LOC_RVALID),
  .FRAME_READY(FRAME_READY), .CRC_FAIL(CRC_FAIL), .IN_SYNC(IN_SYNC),
  .INT_REQ(INT_REQ), .DEEMPH_MODE(DEEMPH_MODE));

/* verif/host_link_model.sv */
// Purpose: Host side of the local access port
// Assumes: Tasks entered just after a rising edge
// Notes: Released lines show inverted values
`timescale 1ns/100ps
module host_link_model (
  input wire logic clk,
  output logic loc_sel,
  output logic [7:0] loc_addr,
  output logic loc_wr,
  output logic [7:0] loc_wdata,
  output logic loc_rd,
  input wire logic [7:0] loc_rdata,
  input wire logic loc_rvalid
);
  initial begin
    {loc_sel, loc_addr, loc_wr, loc_wdata, loc_rd} = 19'h0;
  end
  // ==========================================================
  // Access tasks
  // select opens or resumes
  task sel(input logic [7:0] a);
    loc_sel <= 1'h1;
    loc_addr <= a;
    @(posedge clk);
    loc_sel <= 1'h0;
    loc_addr <= ~a;
  endtask
  task wr(input logic [7:0] v);
    loc_wr <= 1'h1;
    loc_wdata <= v;
    @(posedge clk);
    loc_wr <= 1'h0;
    loc_wdata <= ~v;
  endtask
  // Answer is sampled one edge after the read is taken
  task rd(output logic [7:0] d, output logic ok);
    loc_rd <= 1'h1;
    @(posedge clk);
    loc_rd <= 1'h0;
    @(posedge clk);
    d = loc_rdata;
    ok = loc_rvalid;
  endtask
endmodule // host_link_model

/* verif/tb_top.sv */
// Purpose: Self-checking bench for decoder_status_regs
// Assumes: host_link_model drives the access port
// Notes: Expected values come from an integer model
`timescale 1ns/100ps
module tb_top;
  logic clk, sys_rst, frame_ready, stop_pin, crc_fail, in_sync, dec_hdr_stb;
  logic alloc_valid, frame_decoded, sf_crc_ena, int_req, sel, wr, rd, rvalid, ok;
  logic [7:0] addr, wdata, rdata, d;
  logic [23:0] dec_hdr, hdr, app;
  logic [31:0] sb_concealed;
  logic [1:0] deemph_mode;
  logic [7:0] q[$];
  logic [7:0] zero_a[4] = '{8'h1d, 8'h30, 8'h00, 8'h1e};
  int fails, checks_done, seed, mflags, err;
  int ord[5] = '{1, 2, 3, 4, 0};
  int lo[4] = '{0, 4, 8, 16};
  int sz[4] = '{4, 4, 8, 16};

  decoder_status_regs dut_u (.CLK(clk), .SYS_RST(sys_rst), .LOC_SEL(sel),
    .LOC_ADDR(addr), .LOC_WR(wr), .LOC_WDATA(wdata), .LOC_RD(rd), .LOC_RDATA(rdata),
    .LOC_RVALID(rvalid), .FRAME_READY(frame_ready), .STOP_PIN(stop_pin),
    .CRC_FAIL(crc_fail), .IN_SYNC(in_sync), .DEC_HDR_STB(dec_hdr_stb), .DEC_HDR(dec_hdr),
    .ALLOC_VALID(alloc_valid), .FRAME_DECODED(frame_decoded), .SF_CRC_ENA(sf_crc_ena),
    .SB_CONCEALED(sb_concealed), .INT_REQ(int_req), .DEEMPH_MODE(deemph_mode));
  host_link_model h (.clk(clk), .loc_sel(sel), .loc_addr(addr), .loc_wr(wr),
    .loc_wdata(wdata), .loc_rd(rd), .loc_rdata(rdata), .loc_rvalid(rvalid));

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Generous limit: the whole run needs about 320 cycles
  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  // ==========================================================
  // Helpers
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task rd_item(input logic [7:0] a);
    h.sel(a);
    while (q.size() > 0) begin
      h.rd(d, ok);
      chk({ok, d}, {1'h1, q.pop_front()});
    end
  endtask
  task wr_mask(input logic [7:0] v);
    h.sel(8'h1d);
    h.wr(v);
  endtask
  task fire(input int i);
    case (i)
      0: in_sync <= 1'h0;
      1: in_sync <= 1'h1;
      2: crc_fail <= 1'h1;
      3: stop_pin <= 1'h1;
      default: frame_ready <= 1'h1;
    endcase
    @(posedge clk);
    crc_fail <= 1'h0;
    repeat (8) @(posedge clk);
    {stop_pin, frame_ready} <= 2'h0;
    mflags |= 1 << i;
  endtask
  // ==========================================================
  // Tests
  initial begin
    seed = 32'h16dfb54b;
    sys_rst = 1'h1;
    {frame_ready, stop_pin, crc_fail, in_sync, dec_hdr_stb} = 5'h0;
    {alloc_valid, frame_decoded, sf_crc_ena, dec_hdr, sb_concealed} = 59'h0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    chk(int_req, 1'h0);
    foreach (zero_a[k]) begin
      q = {8'h00, 8'h00};
      rd_item(zero_a[k]);
    end
    $display("reset test done");
    foreach (ord[k]) begin
      wr_mask(8'he0 | (8'h01 << ord[k]));
      fire(ord[k]);
      chk(int_req, 1'h1);
      q = {8'(mflags)};
      rd_item(8'h1e);
      mflags = 0;
      repeat (2) @(posedge clk);
      chk(int_req, 1'h0);
    end
    wr_mask(8'he0);
    fire(2);
    chk(int_req, 1'h0);
    q = {8'(mflags)};
    rd_item(8'h1e);
    mflags = 0;
    $display("event test done");
    fire(1);
    for (int j = 0; j < 4; j++) begin
      hdr = 24'($random(seed));
      dec_hdr <= hdr;
      dec_hdr_stb <= 1'h1;
      alloc_valid <= hdr[5];
      frame_decoded <= (j != 2);
      sf_crc_ena <= (j != 3);
      sb_concealed <= 32'h1 << (lo[j] + (hdr[11:8] % sz[j]));
      @(posedge clk);
      dec_hdr_stb <= 1'h0;
      fire(4);
      if (j != 2) app = (hdr | 24'hf40000) & 24'hfffcff;
      err = hdr[5] * 128 + (j != 2) * 64 + ((j != 3) ? 15 ^ (1 << j) : 0);
      q = {hdr[23:16], hdr[15:8], hdr[7:0], 8'h00};
      rd_item(8'h21);
      q = {app[23:16], app[15:8], app[7:0], 8'h00};
      rd_item(8'h22);
      q = {8'(err), 8'h00};
      rd_item(8'h24);
      chk(deemph_mode, app[1:0]);
    end
    $display("frame test done");
    q = {hdr[23:16]};
    rd_item(8'h21);
    q = {8'(mflags)};
    rd_item(8'h1e);
    mflags = 0;
    q = {hdr[15:8], hdr[7:0], 8'h00};
    rd_item(8'h00);
    $display("resume test done");
    // Out of sync a frame still updates the decoded header and sets the frame-ready flag, nothing else
    fire(0);
    hdr = 24'($random(seed));
    dec_hdr <= hdr;
    dec_hdr_stb <= 1'h1;
    alloc_valid <= ~alloc_valid;
    @(posedge clk);
    dec_hdr_stb <= 1'h0;
    fire(4);
    q = {hdr[23:16], hdr[15:8], hdr[7:0]};
    rd_item(8'h21);
    q = {app[23:16], app[15:8], app[7:0]};
    rd_item(8'h22);
    q = {8'(err)};
    rd_item(8'h24);
    chk(deemph_mode, app[1:0]);
    q = {8'(mflags)};
    rd_item(8'h1e);
    $display("sync loss test done");
    end_of_test();
  end
endmodule // tb_top
